// ===== inc/timer_c_pkg.sv
// Shared constants and types of the reload timer with watchdog and pin output
package timer_c_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_IRQ_FLAG  = 8'h02;
    localparam logic [7:0] IDX_MODE      = 8'h0d;
    localparam logic [7:0] IDX_LOAD_LO   = 8'h0e;
    localparam logic [7:0] IDX_LOAD_HI   = 8'h0f;
    localparam logic [7:0] IDX_OUT_MODE  = 8'h14;
    localparam logic [7:0] IDX_WDOG      = 8'h20;

    // Field positions
    localparam int IRQ_FLAG_BIT = 2;
    localparam int WDOG_BIT     = 1;
    localparam int RELOAD_BIT   = 3;

    // Counter limits
    localparam logic [7:0] COUNT_MAX  = 8'hff;
    localparam logic [7:0] COUNT_ZERO = 8'h00;

    // Reset values
    localparam logic [3:0] MODE_RESET     = 4'h0;
    localparam logic [3:0] LOAD_LO_RESET  = 4'h0;
    localparam logic [3:0] LOAD_HI_RESET  = 4'h0;
    localparam logic [2:0] OUT_MODE_RESET = 3'h0;

    // Pin output modes
    typedef enum logic [2:0] {
        OUT_PORT   = 3'b000,
        OUT_TOGGLE = 3'b001,
        OUT_LOW    = 3'b010,
        OUT_HIGH   = 3'b011,
        OUT_PWM    = 3'b100
    } out_mode_t;

    // Prescaler chain and input clock periods in instruction cycles
    localparam int PRESC_W        = 11;
    localparam int CLKS_PER_TCYC  = 1;
    localparam int unsigned INPUT_PERIOD_TCYC [8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};

endpackage : timer_c_pkg

// ===== inc/timer_link_if.sv
// Signals shared by the counter core, the prescaler taps and the pin waveform unit
`timescale 1ns/1ps
interface timer_link_if;
    logic                  tick;
    logic [2:0]            clk_sel;
    logic                  hold;
    logic                  overflow;
    logic [7:0]            count;
    logic [7:0]            load;
    timer_c_pkg::out_mode_t out_mode;

    modport presc (input clk_sel, input hold, output tick);
    modport core  (output clk_sel, output hold, output overflow, output count,
                   output load, output out_mode, input tick);
    modport wave  (input overflow, input count, input load, input out_mode, input hold);
endinterface : timer_link_if

// ===== design/prescaler_tap.sv
// Prescaler division chain with a selectable tap that yields one-cycle count pulses
`timescale 1ns/1ps
module prescaler_tap (
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    timer_link_if.presc lnk
);
    typedef struct packed {
        logic [timer_c_pkg::PRESC_W-1:0] chain;
        logic                            tick;
    } presc_state_t;

    presc_state_t state_reg;
    presc_state_t state_next;

    function automatic logic [timer_c_pkg::PRESC_W-1:0] tap_mask(input logic [2:0] sel);
        tap_mask = timer_c_pkg::PRESC_W'(timer_c_pkg::INPUT_PERIOD_TCYC[sel]
                                         * timer_c_pkg::CLKS_PER_TCYC - 1);
    endfunction : tap_mask

    always_comb begin
        state_next = state_reg;
        if (lnk.hold) begin
            state_next.chain = '0;
            state_next.tick  = 1'b0;
        end else begin
            state_next.chain = state_reg.chain + 1'b1;
            // One pulse each time the tapped low bits roll over
            state_next.tick  = (state_reg.chain & tap_mask(lnk.clk_sel)) == tap_mask(lnk.clk_sel);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign lnk.tick = state_reg.tick;
endmodule : prescaler_tap

// ===== design/pin_wave.sv
// Timer output pin waveform: toggle, low, high and pulse-width modes
`timescale 1ns/1ps
module pin_wave (
    input  wire logic  mclk_in,
    input  wire logic  reset_n_in,
    timer_link_if.wave lnk,
    input  wire logic  port_data_in,
    output logic       pin_level_out,
    output logic       pin_is_timer_out
);
    typedef struct packed {
        logic level;
        logic pin;
        logic owned;
    } wave_state_t;

    wave_state_t state_reg;
    wave_state_t state_next;
    logic        timer_mode;

    always_comb begin
        state_next = state_reg;
        timer_mode = 1'b0;
        case (lnk.out_mode)
            timer_c_pkg::OUT_TOGGLE: begin
                timer_mode = 1'b1;
                if (lnk.overflow) state_next.level = ~state_reg.level;
            end
            timer_c_pkg::OUT_LOW: begin
                timer_mode = 1'b1;
                if (lnk.overflow) state_next.level = 1'b0;
            end
            timer_c_pkg::OUT_HIGH: begin
                timer_mode = 1'b1;
                if (lnk.overflow) state_next.level = 1'b1;
            end
            // high below load value, low from it to overflow
            timer_c_pkg::OUT_PWM: begin
                timer_mode       = 1'b1;
                state_next.level = lnk.count < lnk.load;
            end
            default: begin
                timer_mode = 1'b0;
            end
        endcase
        // pin follows timer or port data
        state_next.owned = timer_mode;
        state_next.pin   = timer_mode ? state_next.level : port_data_in;
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin_level_out    = state_reg.pin;
    assign pin_is_timer_out = state_reg.owned;
endmodule : pin_wave

// ===== design/timer_c_top.sv
// Eight-bit reload timer with watchdog reset, pin output and an APB register slave
//
// Operation
// - Mode register picks reload and clock tap
// - Count up once per selected pulse
// - Overflow on pulse at maximum count
// - Reload mode reloads write value on overflow
// - Free-running mode wraps to zero
// - Overflow sets flag bit 2 at 002
// - Flag cleared by software, reset, stop
// - Watchdog flag makes overflow reset MCU
// - Output mode register assigns pin to timer
// - Pin driven low after reset
// - Toggle mode inverts pin on overflow
// - Low mode forces pin low on overflow
// - High mode forces pin high on overflow
// - PWM shape from mode and write value
// - Mode register: reload bit, period select
// - Low nibble staged, high nibble loads counter
// - Output codes: port, toggle, low, high
// - High read live, latches low nibble
`timescale 1ns/1ps
module timer_c_top (
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic        stop_mode_in,
    input  wire logic        port_data_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             mcu_reset_out,
    output logic             timer_output_pin_out,
    output logic             pin_is_timer_out
);
    typedef struct packed {
        logic [3:0]  count_hi;
        logic [3:0]  count_lo;
        logic [3:0]  load_hi;
        logic [3:0]  load_lo;
        logic [3:0]  read_lo_latch;
        logic        reload_sel;
        logic [2:0]  clk_sel;
        logic [2:0]  out_mode;
        logic        irq_flag;
        logic        wdog_on;
        logic        mcu_reset;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } core_state_t;

    core_state_t  state_reg;
    core_state_t  state_next;
    timer_link_if lnk ();

    logic         setup_phase;
    logic         write_done;
    logic         read_setup;
    logic         overflow;
    logic         mapped;
    logic [7:0]   count_now;
    logic [7:0]   load_now;
    logic [7:0]   count_inc;

    // Register index match on an aligned word address
    function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
        reg_hit = (addr[1:0] == 2'b00) && (addr[11:2] == {2'b00, idx});
    endfunction : reg_hit

    // Every register that answers a read or a write
    function automatic logic any_hit(input logic [11:0] addr);
        any_hit = reg_hit(addr, timer_c_pkg::IDX_IRQ_FLAG)
                | reg_hit(addr, timer_c_pkg::IDX_MODE)
                | reg_hit(addr, timer_c_pkg::IDX_LOAD_LO)
                | reg_hit(addr, timer_c_pkg::IDX_LOAD_HI)
                | reg_hit(addr, timer_c_pkg::IDX_OUT_MODE)
                | reg_hit(addr, timer_c_pkg::IDX_WDOG);
    endfunction : any_hit

    assign count_now = {state_reg.count_hi, state_reg.count_lo};
    assign load_now  = {state_reg.load_hi, state_reg.load_lo};
    assign count_inc = count_now + 8'h01;

    assign setup_phase = psel_in && !penable_in;
    assign write_done  = psel_in && penable_in && state_reg.pready && pwrite_in;
    assign read_setup  = setup_phase && !pwrite_in;
    assign mapped      = any_hit(paddr_in);

    // overflow at maximum on input pulse
    assign overflow = lnk.tick && (count_now == timer_c_pkg::COUNT_MAX);

    always_comb begin
        state_next = state_reg;

        // Counting; a high nibble write below takes priority
        if (lnk.tick) begin
            if (overflow) begin
                if (state_reg.reload_sel) begin
                    state_next.count_hi = state_reg.load_hi;
                    state_next.count_lo = state_reg.load_lo;
                end else begin
                    state_next.count_hi = timer_c_pkg::COUNT_ZERO[7:4];
                    state_next.count_lo = timer_c_pkg::COUNT_ZERO[3:0];
                end
            end else begin
                state_next.count_hi = count_inc[7:4];
                state_next.count_lo = count_inc[3:0];
            end
        end

        // Watchdog reset pulse
        // overflow with watchdog on
        state_next.mcu_reset = overflow && state_reg.wdog_on;

        // APB answer, registered in the setup cycle: no wait states
        state_next.pready  = setup_phase;
        state_next.pslverr = setup_phase && !mapped;
        if (read_setup) begin
            state_next.prdata = '0;
            if (reg_hit(paddr_in, timer_c_pkg::IDX_IRQ_FLAG)) begin
                state_next.prdata[timer_c_pkg::IRQ_FLAG_BIT] = state_reg.irq_flag;
            end
            if (reg_hit(paddr_in, timer_c_pkg::IDX_LOAD_LO)) begin
                state_next.prdata[3:0] = state_reg.read_lo_latch;
            end
            if (reg_hit(paddr_in, timer_c_pkg::IDX_LOAD_HI)) begin
                state_next.prdata[3:0]   = state_reg.count_hi;
                state_next.read_lo_latch = state_reg.count_lo;
            end
            if (reg_hit(paddr_in, timer_c_pkg::IDX_OUT_MODE)) begin
                state_next.prdata[2:0] = state_reg.out_mode;
            end
            if (reg_hit(paddr_in, timer_c_pkg::IDX_WDOG)) begin
                state_next.prdata[timer_c_pkg::WDOG_BIT] = state_reg.wdog_on;
            end
        end else if (setup_phase) begin
            state_next.prdata = '0;
        end

        // Register writes take effect at the completing access edge
        if (write_done) begin
            if (reg_hit(paddr_in, timer_c_pkg::IDX_MODE)) begin
                state_next.reload_sel = pwdata_in[timer_c_pkg::RELOAD_BIT];
                state_next.clk_sel    = pwdata_in[2:0];
            end
            if (reg_hit(paddr_in, timer_c_pkg::IDX_LOAD_LO)) begin
                state_next.load_lo = pwdata_in[3:0];
            end
            if (reg_hit(paddr_in, timer_c_pkg::IDX_LOAD_HI)) begin
                state_next.load_hi  = pwdata_in[3:0];
                state_next.count_hi = pwdata_in[3:0];
                state_next.count_lo = state_reg.load_lo;
            end
            if (reg_hit(paddr_in, timer_c_pkg::IDX_OUT_MODE)) begin
                state_next.out_mode = pwdata_in[2:0];
            end
            if (reg_hit(paddr_in, timer_c_pkg::IDX_WDOG)) begin
                state_next.wdog_on = pwdata_in[timer_c_pkg::WDOG_BIT];
            end
            if (reg_hit(paddr_in, timer_c_pkg::IDX_IRQ_FLAG)) begin
                if (!pwdata_in[timer_c_pkg::IRQ_FLAG_BIT]) begin
                    state_next.irq_flag = 1'b0;
                end
            end
        end

        // overflow sets flag, wins over software clear
        if (overflow) begin
            state_next.irq_flag = 1'b1;
        end

        // Stop mode clears counter, modes, low nibble and flag
        if (stop_mode_in) begin
            state_next.irq_flag   = 1'b0;
            state_next.count_hi   = timer_c_pkg::COUNT_ZERO[7:4];
            state_next.count_lo   = timer_c_pkg::COUNT_ZERO[3:0];
            state_next.load_lo    = timer_c_pkg::LOAD_LO_RESET;
            state_next.reload_sel = timer_c_pkg::MODE_RESET[timer_c_pkg::RELOAD_BIT];
            state_next.clk_sel    = timer_c_pkg::MODE_RESET[2:0];
            state_next.out_mode   = timer_c_pkg::OUT_MODE_RESET;
            state_next.mcu_reset  = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            state_reg.count_hi      <= timer_c_pkg::COUNT_ZERO[7:4];
            state_reg.count_lo      <= timer_c_pkg::COUNT_ZERO[3:0];
            state_reg.load_hi       <= timer_c_pkg::LOAD_HI_RESET;
            state_reg.load_lo       <= timer_c_pkg::LOAD_LO_RESET;
            state_reg.read_lo_latch <= 4'h0;
            state_reg.reload_sel    <= timer_c_pkg::MODE_RESET[timer_c_pkg::RELOAD_BIT];
            state_reg.clk_sel       <= timer_c_pkg::MODE_RESET[2:0];
            state_reg.out_mode      <= timer_c_pkg::OUT_MODE_RESET;
            state_reg.irq_flag      <= 1'b0;
            state_reg.wdog_on       <= 1'b0;
            state_reg.mcu_reset     <= 1'b0;
            state_reg.pready        <= 1'b0;
            state_reg.pslverr       <= 1'b0;
            state_reg.prdata        <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Link towards prescaler taps and waveform unit
    assign lnk.clk_sel  = state_reg.clk_sel;
    assign lnk.hold     = stop_mode_in;
    assign lnk.overflow = overflow;
    assign lnk.count    = count_now;
    assign lnk.load     = load_now;
    assign lnk.out_mode = timer_c_pkg::out_mode_t'(state_reg.out_mode);

    prescaler_tap u_presc (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .lnk        (lnk.presc)
    );

    pin_wave u_wave (
        .mclk_in          (mclk_in),
        .reset_n_in       (reset_n_in),
        .lnk              (lnk.wave),
        .port_data_in     (port_data_in),
        .pin_level_out    (timer_output_pin_out),
        .pin_is_timer_out (pin_is_timer_out)
    );

    assign prdata_out    = state_reg.prdata;
    assign pready_out    = state_reg.pready;
    assign pslverr_out   = state_reg.pslverr;
    assign mcu_reset_out = state_reg.mcu_reset;
endmodule : timer_c_top

// ===== tb/timer_c_monitor.sv
// Port checker of the timer block, bound to its top module
`timescale 1ns/1ps
module timer_c_monitor (
    input wire logic        mclk_in,
    input wire logic        reset_n_in,
    input wire logic        stop_mode_in,
    input wire logic        port_data_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        mcu_reset_out,
    input wire logic        timer_output_pin_out,
    input wire logic        pin_is_timer_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic rd_acc = pready_out && !pwrite_in;

    property p_rst_pin;
        disable iff (1'b0) !reset_n_in |=> !timer_output_pin_out && !pin_is_timer_out;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("pin not low after reset");
    property p_wdog_pulse;
        mcu_reset_out |=> !mcu_reset_out;
    endproperty
    a_wdog_pulse: assert property (p_wdog_pulse) else $error("reset pulse too long");
    property p_mode_wo;
        rd_acc && paddr_in == 12'h034 |-> prdata_out == 32'h0;
    endproperty
    a_mode_wo: assert property (p_mode_wo) else $error("mode register readable");
    property p_flag_bits;
        rd_acc && paddr_in == 12'h008 |-> (prdata_out & ~32'h4) == 32'h0;
    endproperty
    a_flag_bits: assert property (p_flag_bits) else $error("flag word stray bits");
    property p_out_bits;
        rd_acc && paddr_in == 12'h050 |-> prdata_out[31:3] == 29'h0;
    endproperty
    a_out_bits: assert property (p_out_bits) else $error("output mode stray bits");
    property p_hi_bits;
        rd_acc && paddr_in == 12'h03c |-> prdata_out[31:4] == 28'h0;
    endproperty
    a_hi_bits: assert property (p_hi_bits) else $error("high nibble stray bits");
    property p_port;
        !pin_is_timer_out && $past(!pin_is_timer_out) && $past(reset_n_in, 2)
            |-> timer_output_pin_out == $past(port_data_in);
    endproperty
    a_port: assert property (p_port) else $error("port level not passed");
    property p_stop;
        stop_mode_in |-> ##2 !pin_is_timer_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop kept pin mode");
    property p_own;
        $changed(pin_is_timer_out)
            |-> $past(psel_in && penable_in && pwrite_in && paddr_in == 12'h050, 2)
                || $past(stop_mode_in, 2);
    endproperty
    a_own: assert property (p_own) else $error("pin owner changed alone");

    c_wdog: cover property (mcu_reset_out);
    c_toggle: cover property (pin_is_timer_out && $rose(timer_output_pin_out));
    c_err: cover property (pslverr_out);
endmodule : timer_c_monitor

bind timer_c_top timer_c_monitor u_mon (
    .mclk_in, .reset_n_in, .stop_mode_in, .port_data_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .mcu_reset_out, .timer_output_pin_out, .pin_is_timer_out
);

// ===== tb/pin_load_model.sv
// Load on the timer pin: counts high cycles and level changes
`timescale 1ns/1ps
module pin_load_model (
    input  wire logic        mclk_in,
    input  wire logic        clear_in,
    input  wire logic        pin_in,
    output logic      [15:0] high_cnt_out,
    output logic      [15:0] edge_cnt_out
);
    logic last_reg;
    always_ff @(posedge mclk_in) begin
        last_reg <= pin_in;
        if (clear_in) begin
            high_cnt_out <= 16'h0;
            edge_cnt_out <= 16'h0;
        end else begin
            high_cnt_out <= high_cnt_out + 16'(pin_in);
            edge_cnt_out <= edge_cnt_out + 16'(pin_in != last_reg);
        end
    end
endmodule : pin_load_model

// ===== tb/reload_timer_with_watchdog_and_output_tb.sv
// Self-checking bench of the reload timer with watchdog and pin output
`timescale 1ns/1ps
module reload_timer_with_watchdog_and_output_tb;
    logic        mclk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        stop_mode_in = 1'b0;
    logic        port_data_in = 1'b0;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out, pslverr_out, mcu_reset_out, timer_output_pin_out, pin_is_timer_out;
    logic        clr = 1'b1;
    logic [15:0] high_cnt, edge_cnt;
    logic [31:0] rd;
    logic        err;
    int          error_cnt = 0;
    int          check_count = 0;
    int          wd_pulses = 0;

    always #2.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (mcu_reset_out === 1'b1) wd_pulses <= wd_pulses + 1;

    timer_c_top dut (
        .mclk_in, .reset_n_in, .stop_mode_in, .port_data_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .mcu_reset_out, .timer_output_pin_out, .pin_is_timer_out
    );
    pin_load_model load (.mclk_in, .clear_in(clr), .pin_in(timer_output_pin_out),
        .high_cnt_out(high_cnt), .edge_cnt_out(edge_cnt));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do @(posedge mclk_in); while (pready_out !== 1'b1 && ++n < 16);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 16) check(32'h0, 32'h1);
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdc

    task automatic rng(input logic [11:0] a, input int lo, input int hi);
        apb(1'b0, a, 32'h0);
        check({31'h0, (rd >= lo && rd <= hi)}, 32'h1);
    endtask : rng

    task automatic ld(input logic [3:0] hi, input logic [3:0] lo);
        apb(1'b1, 12'h038, {28'h0, lo});
        apb(1'b1, 12'h03c, {28'h0, hi});
    endtask : ld

    task automatic waitc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : waitc

    task automatic window(input int n);
        clr <= 1'b1;
        @(posedge mclk_in);
        clr <= 1'b0;
        waitc(n + 1);
    endtask : window

    initial begin
        repeat (80000) @(posedge mclk_in);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        @(posedge mclk_in);
        check({31'h0, timer_output_pin_out}, 32'h0);
        rdc(12'h050, 32'h0);
        rdc(12'h034, 32'h0);
        rdc(12'h080, 32'h0);
        apb(1'b0, 12'h3fc, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        $display("test registers done");
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, 12'h034, 32'(s));
            ld(4'h0, 4'h0);
            waitc(8 * timer_c_pkg::INPUT_PERIOD_TCYC[s]);
            rdc(12'h03c, 32'h0);
            rng(12'h038, 7, 10);
        end
        $display("test periods done");
        ld(4'ha, 4'h5);
        rdc(12'h03c, 32'ha);
        rng(12'h038, 5, 7);
        apb(1'b1, 12'h03c, 32'h3);
        rdc(12'h03c, 32'h3);
        rng(12'h038, 5, 7);
        $display("test load done");
        apb(1'b1, 12'h008, 32'h0);
        ld(4'hf, 4'h0);
        waitc(20);
        rdc(12'h008, 32'h0);
        waitc(20);
        rdc(12'h03c, 32'h0);
        rdc(12'h008, 32'h4);
        apb(1'b1, 12'h008, 32'h0);
        rdc(12'h008, 32'h0);
        apb(1'b1, 12'h034, 32'hf);
        ld(4'hc, 4'h0);
        waitc(140);
        rdc(12'h03c, 32'hc);
        $display("test overflow done");
        port_data_in <= 1'b1;
        waitc(3);
        check({31'h0, timer_output_pin_out}, 32'h1);
        port_data_in <= 1'b0;
        apb(1'b1, 12'h050, 32'h1);
        // Owner flag follows the mode register one clock later
        waitc(2);
        check({31'h0, pin_is_timer_out}, 32'h1);
        ld(4'hf, 4'h0);
        window(320);
        check({16'h0, edge_cnt}, 32'ha);
        apb(1'b1, 12'h050, 32'h3);
        waitc(40);
        check({31'h0, timer_output_pin_out}, 32'h1);
        apb(1'b1, 12'h050, 32'h2);
        waitc(40);
        check({31'h0, timer_output_pin_out}, 32'h0);
        apb(1'b1, 12'h034, 32'h7);
        apb(1'b1, 12'h050, 32'h4);
        ld(4'h4, 4'h0);
        window(512);
        check({16'h0, high_cnt}, 32'h80);
        $display("test pin done");
        apb(1'b1, 12'h050, 32'h0);
        apb(1'b1, 12'h080, 32'h2);
        rdc(12'h080, 32'h2);
        ld(4'hf, 4'h0);
        repeat (5) begin
            waitc(20);
            apb(1'b1, 12'h03c, 32'hf);
        end
        check(32'(wd_pulses), 32'h0);
        waitc(60);
        check(32'(wd_pulses), 32'h1);
        apb(1'b1, 12'h080, 32'h0);
        $display("test watchdog done");
        apb(1'b1, 12'h050, 32'h1);
        stop_mode_in <= 1'b1;
        waitc(2);
        stop_mode_in <= 1'b0;
        waitc(1);
        check({31'h0, pin_is_timer_out}, 32'h0);
        rdc(12'h050, 32'h0);
        rdc(12'h008, 32'h0);
        // Reserved output code keeps the pin as a port
        apb(1'b1, 12'h050, 32'h5);
        waitc(2);
        check({31'h0, pin_is_timer_out}, 32'h0);
        rdc(12'h050, 32'h5);
        $display("test stop done");
        report_and_stop();
    end
endmodule : reload_timer_with_watchdog_and_output_tb
